// [core/irf_regfiles.sv]
// Integer and floating register files with operand, jump and memory-access logic
//
// Behaviour
// RULE1 - Integer register zero always reads zero; writes to it are dropped.
// RULE2 - Jump-and-link writes return address into integer register thirty-one.
// RULE3 - Thirty-two general registers, program counter, hi and lo; all 32 bits.
// RULE4 - Thirty-two floating word registers reachable by load, store and move.
// RULE5 - Adjacent floating word pairs form sixteen 64-bit double registers.
// RULE6 - Even word gives bits 31..0, odd word gives bits 63..32.
// RULE7 - Two floating control registers, reachable only by move operations.
// RULE8 - Control/status register holds rounding mode, enables, flags and causes.
// RULE9 - Second control register returns a fixed revision value.
// RULE10 - Instruction words are 32 bits, decoded as register, immediate or jump.
// RULE11 - A new instruction starts on every run cycle; here none starts while a store holds o_busy high.
// RULE12 - Loaded data is invisible to the instruction right after the load.
// RULE13 - Instruction after a branch executes before control flow changes.
// RULE14 - Stores add no latency cycle for the next instruction; here a store raises o_busy until its memory write completes.
// RULE15 - Effective address is base register plus sign-extended 16-bit immediate.
// RULE16 - Byte, halfword, word and unaligned word accesses are supported.
// RULE17 - Partial stores read the containing word, merge bytes, write back.
// RULE18 - Every store goes to memory as well as to the cache.
// RULE19 - Operands are two registers, or a register and a 16-bit immediate.
// RULE20 - Result goes to a destination separate from both sources.
// RULE21 - Floating compare sets the coprocessor-one condition output.
// RULE22 - Absolute jump joins 26-bit field with four upper program counter bits.
// RULE23 - Register jump uses the full 32-bit register value as target.
// RULE24 - Link value is the address after the delay slot.
module irf_regfiles
   import irf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic [31:0] i_instr,
   input wire irf_pkg::irf_fmt_t i_fmt,
   input wire logic [4:0] i_src_a,
   input wire logic [4:0] i_src_b,
   input wire logic [4:0] i_dst,
   input wire logic i_use_imm,
   input wire logic i_wr_en,
   input wire logic [31:0] i_wr_data,
   input wire logic i_jump_abs,
   input wire logic i_jump_reg,
   input wire logic i_link,
   input wire logic i_branch_taken,
   input wire logic [31:0] i_branch_target,
   input wire logic i_hilo_wr,
   input wire logic [31:0] i_hi_data,
   input wire logic [31:0] i_lo_data,
   input wire logic i_load,
   input wire logic [31:0] i_load_data,
   input wire logic i_load_is_fp,
   input wire logic i_store,
   input wire logic i_store_is_fp,
   input wire irf_pkg::irf_size_t i_size,
   input wire logic [31:0] i_mem_rdata,
   input wire logic i_mem_ready,
   input wire logic [4:0] i_fp_src,
   input wire logic [4:0] i_fp_dst,
   input wire logic i_fp_move_to,
   input wire logic i_fp_wr_en,
   input wire logic [31:0] i_fp_wr_data,
   input wire logic i_fp_dbl_wr,
   input wire logic [63:0] i_fp_dbl_data,
   input wire logic i_fp_ctrl_to,
   input wire logic [4:0] i_fp_ctrl_idx,
   input wire logic i_fp_cmp,
   input wire logic i_fp_cmp_result,
   input wire logic [4:0] i_fp_exc,
   output logic [31:0] o_pc,
   output logic [31:0] o_op_a,
   output logic [31:0] o_op_b,
   output logic [31:0] o_hi,
   output logic [31:0] o_lo,
   output logic [31:0] o_fp_word,
   output logic [63:0] o_fp_double,
   output logic [31:0] o_fp_ctrl,
   output logic [1:0] o_round_mode,
   output logic o_cp1_cond,
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic [31:0] o_mem_addr,
   output logic [31:0] o_mem_wdata,
   output logic [3:0] o_mem_be,
   output logic o_busy
);
   import irf_pkg::*;

   // ****************************************************
   // Register state
   // ****************************************************
   logic [31:0] gpr [NUM_REGS];
   logic [31:0] fp_double_register [NUM_REGS];
   logic [31:0] pc, hi, lo, csr;
   logic [31:0] next_pc, next_hi, next_lo, next_csr;
   logic pend_load, pend_fp, pend_jump;
   logic [4:0] pend_dst;
   logic [31:0] pend_target;
   logic next_pend_load, next_pend_fp, next_pend_jump;
   logic [4:0] next_pend_dst;
   logic [31:0] next_pend_target;
   irf_state_t state, next_state;
   logic [31:0] ea, merge_word, st_data, next_st_data, st_addr, next_st_addr;
   logic [3:0] st_be, next_st_be, be;
   logic [31:0] gpr_a, gpr_b, imm_ext, wdata_shift;
   logic [1:0] bo;

   assign gpr_a = (i_src_a == ZERO_IDX) ? RESET_WORD : gpr[i_src_a]; // RULE1
   assign gpr_b = (i_src_b == ZERO_IDX) ? RESET_WORD : gpr[i_src_b]; // RULE1
   assign imm_ext = {{(WORD_W - IMM_W){i_instr[15]}}, i_instr[15:0]}; // RULE15
   assign ea = gpr_a + imm_ext; // RULE15
   assign bo = ea[1:0];

   // ****************************************************
   // Byte lanes for each access size
   // ****************************************************
   always_comb begin
      be = 4'hF;
      wdata_shift = gpr_b;
      case (i_size) // RULE16
         IRF_SZ_BYTE: begin
            be = 4'h1 << bo;
            wdata_shift = gpr_b << {bo, 3'b000};
         end
         IRF_SZ_HALF: begin
            be = bo[1] ? 4'hC : 4'h3;
            wdata_shift = gpr_b << {bo[1], 4'h0};
         end
         IRF_SZ_LEFT: begin
            be = 4'hF >> (2'd3 - bo);
            wdata_shift = gpr_b >> {(2'd3 - bo), 3'b000};
         end
         IRF_SZ_RIGHT: begin
            be = 4'hF << bo;
            wdata_shift = gpr_b << {bo, 3'b000};
         end
         default: begin
            be = 4'hF;
            wdata_shift = gpr_b;
         end
      endcase
      if (i_store_is_fp) begin
         be = 4'hF;
         wdata_shift = fp_double_register[i_fp_src];
      end
   end

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         merge_word[k*8 +: 8] = st_be[k] ? st_data[k*8 +: 8] : i_mem_rdata[k*8 +: 8]; // RULE17
      end
   end

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      next_pc = pc;
      next_hi = hi;
      next_lo = lo;
      next_csr = csr;
      next_pend_load = 1'b0;
      next_pend_fp = pend_fp;
      next_pend_dst = pend_dst;
      next_pend_jump = pend_jump;
      next_pend_target = pend_target;
      next_state = state;
      next_st_data = st_data;
      next_st_addr = st_addr;
      next_st_be = st_be;
      if (i_run && state == IRF_ST_IDLE) begin
         next_pc = pend_jump ? pend_target : pc + PC_STEP; // RULE11 RULE13
         next_pend_jump = 1'b0; // RULE13
         if (i_branch_taken) begin
            next_pend_jump = 1'b1; // RULE13
            next_pend_target = i_branch_target;
         end else if (i_jump_reg) begin
            next_pend_jump = 1'b1;
            next_pend_target = gpr_a; // RULE23
         end else if (i_jump_abs && i_fmt == IRF_FMT_J) begin // RULE10
            next_pend_jump = 1'b1;
            next_pend_target = {pc[31:28], i_instr[TARGET_W-1:0], 2'b00}; // RULE22
         end
         if (i_load) begin
            next_pend_load = 1'b1; // RULE12
            next_pend_fp = i_load_is_fp;
            next_pend_dst = i_load_is_fp ? i_fp_dst : i_dst;
         end
         if (i_store) begin
            next_st_addr = {ea[31:2], 2'b00};
            next_st_data = wdata_shift;
            next_st_be = be;
            // Full words go straight out, partial ones merge first
            next_state = (be == 4'hF) ? IRF_ST_WRITE : IRF_ST_READ; // RULE14 RULE17
         end
         if (i_hilo_wr) begin
            next_hi = i_hi_data; // RULE3
            next_lo = i_lo_data;
         end
         if (i_fp_ctrl_to && i_fp_ctrl_idx == CTRL_CSR_IDX) begin
            next_csr = (csr & ~CSR_WMASK) | (gpr_a & CSR_WMASK); // RULE7 RULE8
         end
      end else if (state == IRF_ST_READ && i_mem_ready) begin
         next_st_data = merge_word; // RULE17
         next_st_be = 4'hF;
         next_state = IRF_ST_WRITE;
      end else if (state == IRF_ST_WRITE && i_mem_ready) begin
         next_state = IRF_ST_IDLE; // RULE18
      end
      if (i_fp_exc != 5'h00) begin
         next_csr[FLAG_LSB +: 5] = next_csr[FLAG_LSB +: 5] | i_fp_exc; // RULE8
         next_csr[CAUSE_LSB +: 5] = i_fp_exc;
      end
      if (i_fp_cmp) begin
         next_csr[COND_BIT] = i_fp_cmp_result; // RULE21
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pc <= RESET_WORD;
         hi <= RESET_WORD;
         lo <= RESET_WORD;
         csr <= RESET_WORD;
         pend_load <= 1'b0;
         pend_fp <= 1'b0;
         pend_dst <= ZERO_IDX;
         pend_jump <= 1'b0;
         pend_target <= RESET_WORD;
         state <= IRF_ST_IDLE;
         st_data <= RESET_WORD;
         st_addr <= RESET_WORD;
         st_be <= 4'h0;
      end else begin
         pc <= next_pc;
         hi <= next_hi;
         lo <= next_lo;
         csr <= next_csr;
         pend_load <= next_pend_load;
         pend_fp <= next_pend_fp;
         pend_dst <= next_pend_dst;
         pend_jump <= next_pend_jump;
         pend_target <= next_pend_target;
         state <= next_state;
         st_data <= next_st_data;
         st_addr <= next_st_addr;
         st_be <= next_st_be;
      end
   end

   // ****************************************************
   // Register file writes
   // ****************************************************
   logic run_ok;
   assign run_ok = i_run && state == IRF_ST_IDLE;

   generate
      for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
         logic [31:0] next_g, next_f;
         always_comb begin
            next_g = gpr[r];
            next_f = fp_double_register[r];
            if (pend_load && !pend_fp && pend_dst == r) begin
               next_g = i_load_data; // RULE12
            end
            if (run_ok && i_link && r == LINK_IDX) begin
               next_g = pc + LINK_OFFSET; // RULE2 RULE24
            end else if (run_ok && i_wr_en && !i_link && i_dst == r) begin
               next_g = i_wr_data; // RULE20
            end
            if (r == 0) begin
               next_g = RESET_WORD; // RULE1
            end
            if (pend_load && pend_fp && pend_dst == r) begin
               next_f = i_load_data; // RULE4
            end
            if (run_ok && i_fp_move_to && i_fp_dst == r) begin
               next_f = gpr_a; // RULE4
            end else if (run_ok && i_fp_wr_en && i_fp_dst == r) begin
               next_f = i_fp_wr_data;
            end else if (run_ok && i_fp_dbl_wr && i_fp_dst[4:1] == r / 2) begin
               next_f = (r % 2 == 0) ? i_fp_dbl_data[31:0] : i_fp_dbl_data[63:32]; // RULE5 RULE6
            end
         end
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               gpr[r] <= RESET_WORD;
               fp_double_register[r] <= RESET_WORD;
            end else begin
               gpr[r] <= next_g;
               fp_double_register[r] <= next_f;
            end
         end
      end
   endgenerate

   // ****************************************************
   // Registered outputs
   // ****************************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pc <= RESET_WORD;
         o_op_a <= RESET_WORD;
         o_op_b <= RESET_WORD;
         o_hi <= RESET_WORD;
         o_lo <= RESET_WORD;
         o_fp_word <= RESET_WORD;
         o_fp_double <= {RESET_WORD, RESET_WORD};
         o_fp_ctrl <= RESET_WORD;
         o_round_mode <= 2'b00;
         o_cp1_cond <= 1'b0;
         o_mem_rd <= 1'b0;
         o_mem_wr <= 1'b0;
         o_mem_addr <= RESET_WORD;
         o_mem_wdata <= RESET_WORD;
         o_mem_be <= 4'h0;
         o_busy <= 1'b0;
      end else begin
         o_pc <= next_pc;
         o_op_a <= gpr_a;
         o_op_b <= i_use_imm ? imm_ext : gpr_b; // RULE19
         o_hi <= next_hi;
         o_lo <= next_lo;
         o_fp_word <= fp_double_register[i_fp_src]; // RULE4
         o_fp_double <= {fp_double_register[{i_fp_src[4:1], 1'b1}], fp_double_register[{i_fp_src[4:1], 1'b0}]}; // RULE5 RULE6
         o_fp_ctrl <= (i_fp_ctrl_idx == CTRL_REV_IDX) ? FP_REVISION : csr; // RULE7 RULE9
         o_round_mode <= next_csr[RM_LSB +: 2]; // RULE8
         o_cp1_cond <= next_csr[COND_BIT]; // RULE21
         o_mem_rd <= (run_ok && i_load) || next_state == IRF_ST_READ;
         o_mem_wr <= next_state == IRF_ST_WRITE; // RULE18
         o_mem_addr <= (run_ok && i_load) ? ea : next_st_addr; // RULE15
         o_mem_wdata <= next_st_data;
         o_mem_be <= (run_ok && i_load) ? be : next_st_be;
         o_busy <= next_state != IRF_ST_IDLE;
      end
   end
endmodule

// [core/irf_pkg.sv]
// Package of constants and types for the integer and floating register files
package irf_pkg;
   // ****************************************************
   // Widths and counts
   // ****************************************************
   localparam int WORD_W = 32;
   localparam int IDX_W = 5;
   localparam int NUM_REGS = 32;
   localparam int IMM_W = 16;
   localparam int TARGET_W = 26;
   localparam int PC_HI_W = 4;
   localparam logic [4:0] ZERO_IDX = 5'h00;
   localparam logic [4:0] LINK_IDX = 5'h1F;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   localparam logic [31:0] PC_STEP = 32'h00000004;
   localparam logic [31:0] LINK_OFFSET = 32'h00000008;
   // Floating unit revision value, arbitrary
   localparam logic [31:0] FP_REVISION = 32'h00000A01;
   // Control/status field positions
   localparam int RM_LSB = 0;
   localparam int FLAG_LSB = 2;
   localparam int ENABLE_LSB = 7;
   localparam int CAUSE_LSB = 12;
   localparam int COND_BIT = 23;
   localparam logic [31:0] CSR_WMASK = 32'h0183FFFF;
   localparam logic [4:0] CTRL_REV_IDX = 5'h00;
   localparam logic [4:0] CTRL_CSR_IDX = 5'h1F;

   // ****************************************************
   // Instruction formats, access sizes and store states
   // ****************************************************
   typedef enum logic [1:0] {
      IRF_FMT_R = 2'b00,
      IRF_FMT_I = 2'b01,
      IRF_FMT_J = 2'b10
   } irf_fmt_t;

   typedef enum logic [2:0] {
      IRF_SZ_BYTE = 3'b000,
      IRF_SZ_HALF = 3'b001,
      IRF_SZ_WORD = 3'b010,
      IRF_SZ_LEFT = 3'b011,
      IRF_SZ_RIGHT = 3'b100
   } irf_size_t;

   typedef enum logic [1:0] {
      IRF_ST_IDLE = 2'b00,
      IRF_ST_READ = 2'b01,
      IRF_ST_WRITE = 2'b10
   } irf_state_t;
endpackage

// [dv/irf_chk.sv]
// Concurrent checks on the register file ports
module irf_chk
   import irf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic [31:0] i_instr,
   input wire logic i_use_imm,
   input wire logic [4:0] i_src_a,
   input wire logic i_store,
   input wire irf_pkg::irf_size_t i_size,
   input wire logic i_mem_ready,
   input wire logic [4:0] i_fp_ctrl_idx,
   input wire logic i_fp_cmp,
   input wire logic i_fp_cmp_result,
   input wire logic o_busy,
   input wire logic [31:0] o_op_a,
   input wire logic [31:0] o_op_b,
   input wire logic [31:0] o_fp_ctrl,
   input wire logic o_cp1_cond,
   input wire logic o_mem_rd,
   input wire logic o_mem_wr,
   input wire logic [31:0] o_mem_addr,
   input wire logic [3:0] o_mem_be
);
   timeunit 1ns;
   timeprecision 100ps;
   logic go;
   assign go = i_run & ~o_busy;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   zero_read_a: assert property (go && i_src_a == ZERO_IDX |=> o_op_a == RESET_WORD)
      else $error("register zero read non-zero");
   imm_sext_a: assert property (go && i_use_imm |=>
      o_op_b == {{16{$past(i_instr[15])}}, $past(i_instr[15:0])}) else $error("bad immediate");
   rev_read_a: assert property (go && i_fp_ctrl_idx == CTRL_REV_IDX |=>
      o_fp_ctrl == FP_REVISION) else $error("revision value wrong");
   cmp_cond_a: assert property (go && i_fp_cmp |=>
      o_cp1_cond == $past(i_fp_cmp_result)) else $error("condition output wrong");
   word_store_a: assert property (go && i_store && i_size == IRF_SZ_WORD |=>
      o_mem_wr && o_mem_be == 4'hF && !o_mem_rd) else $error("word store not written");
   part_store_a: assert property (go && i_store && i_size == IRF_SZ_BYTE |=>
      o_mem_rd && !o_mem_wr && o_mem_addr[1:0] == 2'h0) else $error("partial store no read");
   wr_hold_a: assert property (o_mem_wr && !i_mem_ready |=>
      o_mem_wr && $stable(o_mem_addr)) else $error("write dropped early");
   wr_done_a: assert property (o_mem_wr && i_mem_ready |=> !o_mem_wr && !o_busy)
      else $error("write not released");
endmodule

bind irf_regfiles irf_chk irf_chk_i (.*);

// [dv/irf_mem_model.sv]
// Memory model answering the block's read and write requests
module irf_mem_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_be,
   input wire logic [3:0] i_dly,
   output logic [31:0] o_rdata,
   output logic o_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] mem [64];
   logic [31:0] last_addr, last_data;
   logic [3:0] cnt;
   initial for (int k = 0; k < 64; k++) mem[k] = 32'h11223344;
   // Unselected bus shows inverted data
   assign o_rdata = i_rd ? mem[i_addr[7:2]] : ~mem[i_addr[7:2]];
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 4'h0;
         o_ready <= 1'b0;
      end else if (o_ready) begin
         o_ready <= 1'b0;
         cnt <= 4'h0;
         if (i_wr) begin
            for (int b = 0; b < 4; b++) if (i_be[b]) mem[i_addr[7:2]][8*b+:8] <= i_wdata[8*b+:8];
            last_addr <= i_addr;
            last_data <= i_wdata;
         end
      end else if ((i_rd || i_wr) && cnt == i_dly) begin
         o_ready <= 1'b1;
      end else if (i_rd || i_wr) begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule

// [dv/tb_top.sv]
// Self-checking testbench for the register file block
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import irf_pkg::*;
   logic i_clk, i_rst, i_run, i_use_imm, i_wr_en, i_jump_abs, i_jump_reg, i_link;
   logic i_branch_taken, i_hilo_wr, i_load, i_load_is_fp, i_store, i_store_is_fp, i_mem_ready;
   logic i_fp_move_to, i_fp_wr_en, i_fp_dbl_wr, i_fp_ctrl_to, i_fp_cmp, i_fp_cmp_result;
   logic [31:0] i_instr, i_wr_data, i_branch_target, i_hi_data, i_lo_data, i_load_data;
   logic [31:0] i_mem_rdata, i_fp_wr_data, o_pc, o_op_a, o_op_b, o_hi, o_lo, o_fp_word;
   logic [31:0] o_fp_ctrl, o_mem_addr, o_mem_wdata, sa, sb, p;
   logic [4:0] i_src_a, i_src_b, i_dst, i_fp_src, i_fp_dst, i_fp_ctrl_idx, i_fp_exc;
   logic [63:0] i_fp_dbl_data, o_fp_double;
   logic [1:0] o_round_mode;
   logic [3:0] o_mem_be, dly;
   logic o_cp1_cond, o_mem_rd, o_mem_wr, o_busy;
   irf_fmt_t i_fmt;
   irf_size_t i_size;
   int error_cnt = 0;
   int check_count = 0;
   irf_regfiles irf_regfiles_i (.*);
   irf_mem_model irf_mem_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_rd(o_mem_rd),
      .i_wr(o_mem_wr), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_be(o_mem_be),
      .i_dly(dly), .o_rdata(i_mem_rdata), .o_ready(i_mem_ready));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic step;
      @(posedge i_clk);
      #1;
   endtask
   task automatic clr;
      {i_run, i_use_imm, i_wr_en, i_jump_abs, i_jump_reg, i_link, i_branch_taken} = '0;
      {i_hilo_wr, i_load, i_load_is_fp, i_store, i_store_is_fp, i_fp_move_to} = '0;
      {i_fp_wr_en, i_fp_dbl_wr, i_fp_ctrl_to, i_fp_cmp, i_fp_cmp_result} = '0;
   endtask
   task automatic issue;
      i_run = 1'b1;
      step;
      sa = o_op_a;
      sb = o_op_b;
      clr;
      step;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] r, input logic [31:0] v);
      i_dst = r;
      i_wr_data = v;
      i_wr_en = 1'b1;
      issue;
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic t_int;
      wr(5'h00, 32'hFFFFFFFF);
      wr(5'h05, 32'h80000010);
      wr(5'h06, 32'h00000001);
      i_src_b = 5'h06;
      issue;
      chk(sa, 32'h0);
      chk(sb, 32'h1);
      i_src_a = 5'h05;
      i_use_imm = 1'b1;
      i_instr = 32'h00008001;
      issue;
      chk(sa, 32'h80000010);
      chk(sb, 32'hFFFF8001);
      i_hilo_wr = 1'b1;
      i_hi_data = 32'hDEAD0001;
      i_lo_data = 32'h0000BEEF;
      issue;
      chk({o_hi, o_lo}, 64'hDEAD00010000BEEF);
   endtask
   task automatic t_flow;
      p = o_pc;
      i_fmt = IRF_FMT_J;
      i_instr = 32'h00000040;
      i_jump_abs = 1'b1;
      i_link = 1'b1;
      issue;
      i_fmt = IRF_FMT_R;
      issue;
      chk(o_pc, {p[31:28], 28'h0000100});
      i_src_a = 5'h1F;
      issue;
      chk(sa, p + 32'h8);
      wr(5'h07, 32'h00001230);
      i_src_a = 5'h07;
      i_jump_reg = 1'b1;
      issue;
      issue;
      chk(o_pc, 32'h00001230);
      i_branch_taken = 1'b1;
      i_branch_target = 32'h00000200;
      issue;
      issue;
      chk(o_pc, 32'h00000200);
   endtask
   task automatic t_load;
      wr(5'h09, 32'h11111111);
      i_load = 1'b1;
      i_run = 1'b1;
      step;
      i_load = 1'b0;
      i_load_data = 32'h22222222;
      i_src_a = 5'h09;
      step;
      chk(o_op_a, 32'h11111111);
      clr;
      step;
      issue;
      chk(sa, 32'h22222222);
   endtask
   task automatic st(input irf_size_t sz, input logic [15:0] off, input logic [3:0] d);
      dly = d;
      i_fmt = IRF_FMT_I;
      i_size = sz;
      i_instr = {16'h0000, off};
      i_src_a = 5'h03;
      i_src_b = 5'h04;
      i_store = 1'b1;
      issue;
      for (int k = 0; k < 30 && o_busy !== 1'b0; k++) step;
      chk(o_busy, 1'b0);
   endtask
   task automatic t_store;
      wr(5'h03, 32'h00000100);
      wr(5'h04, 32'hCAFE00A5);
      st(IRF_SZ_WORD, 16'hFFFC, 4'h0);
      chk({irf_mem_model_i.last_addr, irf_mem_model_i.last_data}, 64'hFC_CAFE00A5);
      st(IRF_SZ_BYTE, 16'h0001, 4'h3);
      chk({irf_mem_model_i.last_addr, irf_mem_model_i.last_data}, 64'h100_1122A544);
      st(IRF_SZ_HALF, 16'h0006, 4'h2);
      chk(irf_mem_model_i.last_data, 32'h00A53344);
      st(IRF_SZ_LEFT, 16'h0009, 4'h1);
      chk(irf_mem_model_i.last_data, 32'h1122CAFE);
      st(IRF_SZ_RIGHT, 16'h000D, 4'h0);
      chk(irf_mem_model_i.last_data, 32'hFE00A544);
      i_fmt = IRF_FMT_R;
   endtask
   task automatic t_fp;
      wr(5'h01, 32'hFFFFFFFF);
      i_src_a = 5'h01;
      i_fp_dst = 5'h02;
      i_fp_move_to = 1'b1;
      issue;
      i_fp_dst = 5'h03;
      i_fp_wr_data = 32'hC0000001;
      i_fp_wr_en = 1'b1;
      issue;
      i_fp_src = 5'h02;
      i_fp_ctrl_idx = CTRL_REV_IDX;
      issue;
      chk(o_fp_word, 32'hFFFFFFFF);
      chk(o_fp_double, 64'hC0000001FFFFFFFF);
      chk(o_fp_ctrl, FP_REVISION);
      i_fp_dst = 5'h06;
      i_fp_dbl_data = 64'h0123456789ABCDEF;
      i_fp_dbl_wr = 1'b1;
      issue;
      i_fp_src = 5'h07;
      i_fp_ctrl_idx = CTRL_CSR_IDX;
      i_fp_ctrl_to = 1'b1;
      issue;
      chk(o_fp_word, 32'h01234567);
      chk(o_fp_ctrl, CSR_WMASK);
      chk(o_round_mode, 2'h3);
      i_fp_cmp = 1'b1;
      issue;
      chk({o_cp1_cond, o_fp_ctrl[23]}, 2'h0);
      i_fp_cmp = 1'b1;
      i_fp_cmp_result = 1'b1;
      issue;
      chk({o_cp1_cond, o_fp_ctrl[23]}, 2'h3);
      i_fp_exc = 5'h05;
      step;
      i_fp_exc = 5'h00;
      step;
      chk(o_fp_ctrl, 32'h01825FFF);
   endtask
   initial begin
      clr;
      {i_instr, i_wr_data, i_branch_target, i_hi_data, i_lo_data, i_load_data} = '0;
      {i_src_a, i_src_b, i_dst, i_fp_src, i_fp_dst, i_fp_ctrl_idx, i_fp_exc} = '0;
      {i_fp_wr_data, i_fp_dbl_data, dly} = '0;
      i_fmt = IRF_FMT_R;
      i_size = IRF_SZ_WORD;
      i_rst = 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      t_int;
      t_flow;
      t_load;
      t_store;
      t_fp;
      final_report;
   end
   initial begin
      #20000;
      error_cnt++;
      final_report;
   end
endmodule
